// [logic/scd_pkg.sv]
package scd_pkg;
	typedef enum logic [1:0] {TX_IDLE, TX_BITS, TX_WAIT, TX_RETRY}
		scd_tx_state_t;
	typedef enum logic [1:0] {RX_IDLE, RX_BITS, RX_GAP, RX_ERR}
		scd_rx_state_t;
endpackage

// [logic/scd_regs.svh]
`ifndef SCD_REGS_SVH
`define SCD_REGS_SVH

// Register byte offsets, one aligned word each
`define SCD_OFS_MODE 5'h00
`define SCD_OFS_DIVISOR 5'h04
`define SCD_OFS_CTRL 5'h08
`define SCD_OFS_TXDATA 5'h0c
`define SCD_OFS_STATUS 5'h10
`define SCD_OFS_RXDATA 5'h14
`define SCD_OFS_CARDMODE 5'h18

// Mode register fields
`define SCD_MODE_ALT 7
`define SCD_MODE_ODD 4
`define SCD_MODE_PS_HI 1
`define SCD_MODE_PS_LO 0

// Control register fields
`define SCD_CTRL_TXIE 7
`define SCD_CTRL_RXIE 6
`define SCD_CTRL_TXEN 5
`define SCD_CTRL_RXEN 4
`define SCD_CTRL_CKFIX 1
`define SCD_CTRL_CKOUT 0

// Status register fields
`define SCD_ST_TXEMPTY 7
`define SCD_ST_RXFULL 6
`define SCD_ST_OVERRUN 5
`define SCD_ST_ERRSIG 4
`define SCD_ST_PARFAIL 3
`define SCD_ST_TXDONE 2

// Card mode register fields and writable mask
`define SCD_CM_ORDER 3
`define SCD_CM_INVERT 2
`define SCD_CM_CARD 0
`define SCD_CM_MASK 8'h0d

// Reset values
`define SCD_RST_REG8 8'h00
`define SCD_RST_TXEMPTY 1'b1
`define SCD_RST_TXDONE 1'b1

// Timing in base ticks (372 per etu) and etu positions in a frame
`define SCD_ETU_BASE 9'd372
`define SCD_HALF_BASE 9'd185
`define SCD_PAR_ETU 4'd9
`define SCD_REL_ETU 4'd10
`define SCD_TXERR_ETU 4'd11
`define SCD_GUARD_ETU 4'd12
`define SCD_RETRY_ETU 4'd14
`define SCD_RXERR_ETU 4'd10
`define SCD_RXEND_ETU 4'd11

`endif

// [logic/scd_top.sv]
// What this block does
// - Direct convention: LSB first, plain levels.
// - Inverse convention: MSB first, inverted data.
// - Even parity over eight data bits.
// - Inversion spares parity; odd select flips it.
// - Bit clock only from internal generator.
// - Clock pin runs at base rate when enabled.
// - Base period from divisor and prescaler exponent.
// - Prescaler code selects exponent zero to three.
// - Gear division stretches the operating clock.
// - Card mode hands pins to serial function.
// - Data write clears done flag, sends character.
// - Done flag with enable requests tx interrupt.
// - Error signal flag requests error interrupt.
// - Done point depends on alternate card mode.
// - Done flag on done only; retries hold flag.
// - Good character sets full flag, interrupt.
// - Overrun or parity fail requests error interrupt.
// - Errored characters raise no full flag.
// - Parity-failed character still stored.
// - Frame: start, eight data, parity.
// - At least two etu guard after parity.
// - Parity fail drives low one etu at 10.5.
// - Card error signal causes delayed resend.
`timescale 1ns/1ps
`include "scd_regs.svh"
module scd_top #(
	parameter int GEAR_W = 2
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [GEAR_W-1:0] i_gear_sel,
	input wire logic i_data,
	output logic o_data,
	output logic o_data_oe,
	output logic o_card_clk,
	output logic o_card_clk_oe,
	output logic o_pin_serial,
	output logic o_tx_irq,
	output logic o_rx_irq,
	output logic o_error_irq,
	input wire logic [4:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest
);
	localparam int CW = 14 + (1 << GEAR_W);

	// Gear exponents above seven are refused here; the counter width grows with GEAR_W
	if (GEAR_W < 1 || GEAR_W > 3) begin : g_gear_check
		$error("GEAR_W must be 1 to 3");
	end

	// Maps a byte to line order and polarity; it is its own inverse
	function automatic logic [7:0] map_byte(input logic [7:0] d,
		input logic msb_first, input logic inv);
		logic [7:0] x;
		logic [7:0] r;
		x = inv ? ~d : d;
		for (int i = 0; i < 8; i++) begin
			r[i] = x[7-i];
		end
		return msb_first ? r : x;
	endfunction

	logic [7:0] mode_q;
	logic [7:0] divisor_q;
	logic [7:0] ctrl_q;
	logic [7:0] txd_q;
	logic [7:0] rxd_q;
	logic [7:0] cmode_q;
	logic tx_empty_q, rx_full_q, overrun_q, err_sig_q, par_fail_q;
	logic tx_done_q;
	logic ack_q;
	logic [31:0] rdata_q;
	logic [CW-1:0] half_cnt_q;
	logic [CW-1:0] half_lim;
	logic [4:0] shamt;
	logic half_tick, base_tick, clk_q;
	scd_pkg::scd_tx_state_t tx_state_q;
	scd_pkg::scd_rx_state_t rx_state_q;
	logic [8:0] tx_base_q, rx_base_q;
	logic [3:0] tx_etu_q, rx_etu_q;
	logic [7:0] tx_byte_q, rx_raw_q;
	logic data_prev_q, data_q, oe_q;
	logic alt_mode, odd_par, card_mode, tx_en, rx_en;
	logic wr_go, rd_go, req;
	logic tx_start, tx_done_set, tx_err_set;
	logic rx_samp, rx_par_bad, rx_good, rx_bad, rx_edge;
	logic [7:0] tx_line;
	logic tx_par;

	assign alt_mode = mode_q[`SCD_MODE_ALT];
	assign odd_par = mode_q[`SCD_MODE_ODD];
	assign card_mode = cmode_q[`SCD_CM_CARD];
	assign tx_en = ctrl_q[`SCD_CTRL_TXEN];
	assign rx_en = ctrl_q[`SCD_CTRL_RXEN];

	// Bus handshake: one wait state, write acts when waitrequest is low
	assign req = i_avs_read | i_avs_write;
	assign o_avs_waitrequest = req & ~ack_q;
	assign wr_go = i_avs_write & ack_q;
	assign rd_go = i_avs_read & ack_q;
	assign o_avs_readdata = rdata_q;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0;
		end else begin
			ack_q <= req & ~ack_q;
			if (i_avs_read & ~ack_q) begin
				case (i_avs_address)
				`SCD_OFS_MODE: rdata_q <= {24'h0, mode_q};
				`SCD_OFS_DIVISOR: rdata_q <= {24'h0, divisor_q};
				`SCD_OFS_CTRL: rdata_q <= {24'h0, ctrl_q};
				`SCD_OFS_TXDATA: rdata_q <= {24'h0, txd_q};
				`SCD_OFS_STATUS: rdata_q <= {24'h0, tx_empty_q,
					rx_full_q, overrun_q, err_sig_q, par_fail_q,
					tx_done_q, 2'b00};
				`SCD_OFS_RXDATA: rdata_q <= {24'h0, rxd_q};
				`SCD_OFS_CARDMODE: rdata_q <= {24'h0, cmode_q};
				default: rdata_q <= 32'h0;
				endcase
			end
		end
	end

	// Software-written configuration registers
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			mode_q <= `SCD_RST_REG8;
			divisor_q <= `SCD_RST_REG8;
			ctrl_q <= `SCD_RST_REG8;
			txd_q <= `SCD_RST_REG8;
			cmode_q <= `SCD_RST_REG8;
		end else if (wr_go) begin
			case (i_avs_address)
			`SCD_OFS_MODE: mode_q <= i_avs_writedata[7:0];
			`SCD_OFS_DIVISOR: divisor_q <= i_avs_writedata[7:0];
			`SCD_OFS_CTRL: ctrl_q <= i_avs_writedata[7:0];
			`SCD_OFS_TXDATA: txd_q <= i_avs_writedata[7:0];
			`SCD_OFS_CARDMODE:
				cmode_q <= i_avs_writedata[7:0] & `SCD_CM_MASK;
			default: ;
			endcase
		end
	end

	// Bit rate generator on the internal clock only, half base period
	// is (divisor+1) * 2^(2n) * gear ratio cycles
	assign shamt = 5'({mode_q[`SCD_MODE_PS_HI:`SCD_MODE_PS_LO], 1'b0})
		+ 5'(i_gear_sel);
	assign half_lim = (CW'(divisor_q) + CW'(1)) << shamt;
	assign half_tick = (half_cnt_q >= half_lim - CW'(1));
	assign base_tick = half_tick & clk_q;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			half_cnt_q <= '0;
			clk_q <= 1'b0;
		end else if (half_tick) begin
			half_cnt_q <= '0;
			clk_q <= ~clk_q;
		end else begin
			half_cnt_q <= half_cnt_q + CW'(1);
		end
	end

	// Card clock pin: running, or held at a fixed level in alt mode
	always_comb begin
		if (ctrl_q[`SCD_CTRL_CKOUT])
			o_card_clk = clk_q;
		else
			o_card_clk = alt_mode & ctrl_q[`SCD_CTRL_CKFIX];
	end
	assign o_card_clk_oe = card_mode & (ctrl_q[`SCD_CTRL_CKOUT] | alt_mode);
	assign o_pin_serial = card_mode;

	// Transmit timing events
	assign tx_start = base_tick & tx_en & card_mode & ~tx_empty_q &
		(tx_state_q == scd_pkg::TX_IDLE);
	assign tx_err_set = base_tick & (tx_state_q == scd_pkg::TX_WAIT) &
		(tx_etu_q == `SCD_TXERR_ETU) & (tx_base_q == 9'd0) & ~i_data;
	assign tx_done_set = base_tick & (tx_state_q == scd_pkg::TX_WAIT) &
		((alt_mode & (tx_etu_q == `SCD_TXERR_ETU) &
		(tx_base_q == 9'd0) & i_data) |
		(~alt_mode & (tx_etu_q == `SCD_GUARD_ETU) &
		(tx_base_q == `SCD_HALF_BASE)));

	// Transmitter: frame, release, error sampling, guard and resend
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			tx_state_q <= scd_pkg::TX_IDLE;
			tx_base_q <= 9'd0;
			tx_etu_q <= 4'd0;
			tx_byte_q <= 8'h00;
		end else if (~tx_en) begin
			tx_state_q <= scd_pkg::TX_IDLE;
		end else if (base_tick) begin
			if (tx_base_q == `SCD_ETU_BASE - 9'd1) begin
				tx_base_q <= 9'd0;
				tx_etu_q <= tx_etu_q + 4'd1;
			end else begin
				tx_base_q <= tx_base_q + 9'd1;
			end
			case (tx_state_q)
			scd_pkg::TX_IDLE: begin
				if (tx_start) begin
					tx_state_q <= scd_pkg::TX_BITS;
					tx_byte_q <= txd_q;
					tx_base_q <= 9'd0;
					tx_etu_q <= 4'd0;
				end
			end
			scd_pkg::TX_BITS: begin
				if (tx_etu_q == `SCD_REL_ETU)
					tx_state_q <= scd_pkg::TX_WAIT;
			end
			scd_pkg::TX_WAIT: begin
				if (tx_err_set)
					tx_state_q <= scd_pkg::TX_RETRY;
				else if (tx_etu_q == `SCD_GUARD_ETU &&
					tx_base_q == `SCD_HALF_BASE)
					tx_state_q <= scd_pkg::TX_IDLE;
			end
			scd_pkg::TX_RETRY: begin
				if (tx_etu_q == `SCD_RETRY_ETU) begin
					tx_state_q <= scd_pkg::TX_BITS;
					tx_base_q <= 9'd0;
					tx_etu_q <= 4'd0;
				end
			end
			default: tx_state_q <= scd_pkg::TX_IDLE;
			endcase
		end
	end

	// Line order, polarity and parity of the character in flight
	assign tx_line = map_byte(tx_byte_q, cmode_q[`SCD_CM_ORDER],
		cmode_q[`SCD_CM_INVERT]);
	assign tx_par = ^tx_byte_q ^ odd_par;

	// Receive timing events, sampled mid-bit
	assign rx_edge = rx_en & card_mode & data_prev_q & ~i_data &
		(rx_state_q == scd_pkg::RX_IDLE);
	assign rx_samp = base_tick & (rx_base_q == `SCD_HALF_BASE);
	assign rx_par_bad = ^rx_raw_q ^ i_data ^ odd_par;
	assign rx_good = rx_samp & (rx_state_q == scd_pkg::RX_BITS) &
		(rx_etu_q == `SCD_PAR_ETU) & ~rx_par_bad;
	assign rx_bad = rx_samp & (rx_state_q == scd_pkg::RX_BITS) &
		(rx_etu_q == `SCD_PAR_ETU) & rx_par_bad;

	// Receiver: align to the start edge, gather bits, signal errors
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			rx_state_q <= scd_pkg::RX_IDLE;
			rx_base_q <= 9'd0;
			rx_etu_q <= 4'd0;
			rx_raw_q <= 8'h00;
			data_prev_q <= 1'b1;
		end else begin
			data_prev_q <= i_data;
			if (rx_edge) begin
				rx_state_q <= scd_pkg::RX_BITS;
				rx_base_q <= 9'd0;
				rx_etu_q <= 4'd0;
			end else if (~rx_en) begin
				rx_state_q <= scd_pkg::RX_IDLE;
			end else if (base_tick &&
				rx_state_q != scd_pkg::RX_IDLE) begin
				if (rx_base_q == `SCD_ETU_BASE - 9'd1) begin
					rx_base_q <= 9'd0;
					rx_etu_q <= rx_etu_q + 4'd1;
				end else begin
					rx_base_q <= rx_base_q + 9'd1;
				end
				case (rx_state_q)
				scd_pkg::RX_BITS: begin
					if (rx_samp && rx_etu_q >= 4'd1 &&
						rx_etu_q <= 4'd8)
						rx_raw_q[3'(rx_etu_q - 4'd1)] <= i_data;
					if (rx_good)
						rx_state_q <= scd_pkg::RX_IDLE;
					else if (rx_bad)
						rx_state_q <= scd_pkg::RX_GAP;
				end
				scd_pkg::RX_GAP: begin
					if (rx_samp && rx_etu_q == `SCD_RXERR_ETU)
						rx_state_q <= scd_pkg::RX_ERR;
				end
				scd_pkg::RX_ERR: begin
					if (rx_samp && rx_etu_q == `SCD_RXEND_ETU)
						rx_state_q <= scd_pkg::RX_IDLE;
				end
				default: rx_state_q <= scd_pkg::RX_IDLE;
				endcase
			end
		end
	end

	// Receive data register: good characters unless full, failed ones too
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			rxd_q <= 8'h00;
		end else if ((rx_good & ~rx_full_q) | rx_bad) begin
			rxd_q <= map_byte(rx_raw_q, cmode_q[`SCD_CM_ORDER],
				cmode_q[`SCD_CM_INVERT]);
		end
	end

	// Line driver: own bits and error signal only, released otherwise
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			oe_q <= 1'b0;
			data_q <= 1'b1;
		end else begin
			oe_q <= card_mode & ((tx_state_q == scd_pkg::TX_BITS) |
				(rx_state_q == scd_pkg::RX_ERR));
			if (rx_state_q == scd_pkg::RX_ERR)
				data_q <= 1'b0;
			else if (tx_etu_q == 4'd0)
				data_q <= 1'b0;
			else if (tx_etu_q <= 4'd8)
				data_q <= tx_line[3'(tx_etu_q - 4'd1)];
			else
				data_q <= tx_par;
		end
	end
	assign o_data = data_q;
	assign o_data_oe = oe_q;

	// Status flags; hardware set wins over a clear by software
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			tx_empty_q <= `SCD_RST_TXEMPTY;
			tx_done_q <= `SCD_RST_TXDONE;
			rx_full_q <= 1'b0;
			overrun_q <= 1'b0;
			err_sig_q <= 1'b0;
			par_fail_q <= 1'b0;
		end else begin
			if (wr_go && i_avs_address == `SCD_OFS_STATUS) begin
				if (!i_avs_writedata[`SCD_ST_TXEMPTY])
					tx_empty_q <= 1'b0;
				if (!i_avs_writedata[`SCD_ST_TXDONE])
					tx_done_q <= 1'b0;
				if (!i_avs_writedata[`SCD_ST_RXFULL])
					rx_full_q <= 1'b0;
				if (!i_avs_writedata[`SCD_ST_OVERRUN])
					overrun_q <= 1'b0;
				if (!i_avs_writedata[`SCD_ST_ERRSIG])
					err_sig_q <= 1'b0;
				if (!i_avs_writedata[`SCD_ST_PARFAIL])
					par_fail_q <= 1'b0;
			end
			if (wr_go && i_avs_address == `SCD_OFS_TXDATA) begin
				tx_empty_q <= 1'b0;
				tx_done_q <= 1'b0;
			end
			if (rd_go && i_avs_address == `SCD_OFS_RXDATA)
				rx_full_q <= 1'b0;
			if (tx_done_set) begin
				tx_done_q <= 1'b1;
				tx_empty_q <= 1'b1;
			end
			if (tx_err_set)
				err_sig_q <= 1'b1;
			if (rx_good & ~rx_full_q)
				rx_full_q <= 1'b1;
			if (rx_good & rx_full_q)
				overrun_q <= 1'b1;
			if (rx_bad)
				par_fail_q <= 1'b1;
		end
	end

	// Interrupt request levels
	assign o_tx_irq = tx_done_q & ctrl_q[`SCD_CTRL_TXIE];
	assign o_rx_irq = rx_full_q & ctrl_q[`SCD_CTRL_RXIE];
	assign o_error_irq = (err_sig_q | par_fail_q | overrun_q) &
		ctrl_q[`SCD_CTRL_RXIE];

	// Checks
	a_start_low: assert property (@(posedge i_clk) disable iff (i_reset)
		$rose(tx_state_q == scd_pkg::TX_BITS) |=> o_data_oe && !o_data)
		else $error("start bit not driven low");
	a_line_release: assert property (@(posedge i_clk)
		disable iff (i_reset)
		tx_state_q == scd_pkg::TX_WAIT && rx_state_q == scd_pkg::RX_IDLE
		|=> !o_data_oe)
		else $error("line driven outside own bits");
	a_error_pulse: assert property (@(posedge i_clk)
		disable iff (i_reset)
		$rose(rx_state_q == scd_pkg::RX_ERR) && card_mode
		|=> o_data_oe && !o_data)
		else $error("error signal not driven low");
	a_txdone_irq: assert property (@(posedge i_clk)
		disable iff (i_reset)
		tx_done_set && ctrl_q[`SCD_CTRL_TXIE] |=> o_tx_irq)
		else $error("done flag did not raise tx irq");
	a_errsig_irq: assert property (@(posedge i_clk)
		disable iff (i_reset)
		tx_err_set && ctrl_q[`SCD_CTRL_RXIE] |=> o_error_irq && err_sig_q)
		else $error("error signal did not raise error irq");
	a_bad_no_full: assert property (@(posedge i_clk)
		disable iff (i_reset)
		rx_bad |=> $stable(rx_full_q) && par_fail_q)
		else $error("errored character touched full flag");
	a_bad_stored: assert property (@(posedge i_clk)
		disable iff (i_reset)
		rx_bad |=> rxd_q == map_byte($past(rx_raw_q),
			cmode_q[`SCD_CM_ORDER], cmode_q[`SCD_CM_INVERT]))
		else $error("failed character not stored");
	a_write_clears: assert property (@(posedge i_clk)
		disable iff (i_reset)
		wr_go && i_avs_address == `SCD_OFS_TXDATA && !tx_done_set
		|=> !tx_done_q && !tx_empty_q)
		else $error("data write left done flag set");
	a_clk_toggle: assert property (@(posedge i_clk) disable iff (i_reset)
		half_tick |=> clk_q != $past(clk_q))
		else $error("card clock did not toggle");
	a_retry_wait: assert property (@(posedge i_clk)
		disable iff (i_reset)
		tx_err_set && tx_en |=> tx_state_q == scd_pkg::TX_RETRY)
		else $error("card error did not start resend wait");
endmodule

// [tb/scd_card.sv]
`timescale 1ns/1ps
// Card on the shared line: takes device frames, sends its own on command
module scd_card #(
	parameter int ETU = 744
) (
	input wire logic i_clk,
	input wire logic i_line,
	input wire logic i_nack,
	input wire logic i_send,
	input wire logic [8:0] i_raw,
	output logic o_low,
	output logic [8:0] o_raw,
	output logic [7:0] o_count,
	output logic o_err_seen
);
	// Receive a device frame, mid-bit sampling, optional error signal
	task automatic take();
		repeat (ETU / 2) @(posedge i_clk);
		for (int i = 0; i < 9; i++) begin
			repeat (ETU) @(posedge i_clk);
			o_raw <= {i_line, o_raw[8:1]};
		end
		repeat (ETU) @(posedge i_clk);
		if (i_nack) begin
			// Low for one etu from 10.5 etu after the start edge
			o_low <= 1'b1;
			repeat (ETU) @(posedge i_clk);
			o_low <= 1'b0;
		end
		o_count <= o_count + 8'h01;
	endtask

	// Send start, eight data and parity levels, then watch for an error
	task automatic give(input logic [8:0] r);
		o_low <= 1'b1;
		repeat (ETU) @(posedge i_clk);
		for (int i = 0; i < 9; i++) begin
			o_low <= !r[i];
			repeat (ETU) @(posedge i_clk);
		end
		o_low <= 1'b0;
		repeat (ETU) @(posedge i_clk);
		o_err_seen <= !i_line;
		repeat (ETU) @(posedge i_clk);
		o_count <= o_count + 8'h01;
	endtask

	// Idle line is left to the pull-up; frames start on a low level
	initial begin
		o_low = 1'b0;
		o_raw = 9'h000;
		o_count = 8'h00;
		o_err_seen = 1'b0;
		forever begin
			@(posedge i_clk);
			if (i_send) begin
				give(i_raw);
			end else if (i_line === 1'b0) begin
				take();
			end
		end
	end
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
`include "scd_regs.svh"
module tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] gear = 2'h0;
	logic [4:0] addr = 5'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic nack = 1'b0;
	logic send = 1'b0;
	logic [8:0] craw = 9'h000;
	logic [8:0] q;
	wire line, dat, oe, cclk, cclk_oe, pser, tx_irq, rx_irq, error_irq, waitreq;
	wire card_low, err_seen;
	wire [31:0] rdata;
	wire [8:0] got_raw;
	wire [7:0] got_n;
	int error_cnt = 0;
	int checks = 0;
	int cyc = 0;
	int d0, d1, dx;

	// Resolved data line: device drive, else card pull-down, else pull-up
	assign line = oe ? dat : !card_low;
	always #2 clk = ~clk;

	scd_top u_scd_top (.i_clk(clk), .i_reset(rst), .i_gear_sel(gear),
		.i_data(line), .o_data(dat), .o_data_oe(oe), .o_card_clk(cclk),
		.o_card_clk_oe(cclk_oe), .o_pin_serial(pser), .o_tx_irq(tx_irq),
		.o_rx_irq(rx_irq), .o_error_irq(error_irq), .i_avs_address(addr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
		.o_avs_readdata(rdata), .o_avs_waitrequest(waitreq));
	scd_card u_scd_card (.i_clk(clk), .i_line(line), .i_nack(nack),
		.i_send(send), .i_raw(craw), .o_low(card_low), .o_raw(got_raw),
		.o_count(got_n), .o_err_seen(err_seen));

	task automatic test_done();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Cut a hang short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 99000) begin
			error_cnt++;
			test_done();
		end
	end

	task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// One Avalon transfer, held until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [7:0] d, output logic [8:0] r);
		int n;
		n = 0;
		@(posedge clk);
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= {24'h0, d};
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 40);
		r = {1'b0, rdata[7:0]};
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 40) error_cnt++;
	endtask

	task automatic wreg(input logic [4:0] a, input logic [7:0] d);
		logic [8:0] r;
		bus(1'b1, a, d, r);
	endtask

	task automatic rreg(input logic [4:0] a, output logic [8:0] r);
		bus(1'b0, a, 8'h00, r);
	endtask

	task automatic wait_card(input logic [7:0] n0);
		int n;
		n = 0;
		while (got_n === n0 && n < 30000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 30000) error_cnt++;
	endtask

	// Line levels of data and parity for either convention
	function automatic logic [8:0] exp_line(input logic [7:0] d,
		input logic cv, input logic odd);
		logic [8:0] r;
		for (int i = 0; i < 8; i++) r[i] = cv ? ~d[7 - i] : d[i];
		r[8] = ^d ^ odd;
		return r;
	endfunction

	task automatic t_reset();
		rreg(`SCD_OFS_STATUS, q);
		chk(q, 9'h084);
		rreg(`SCD_OFS_CTRL, q);
		chk(q, 9'h000);
		rreg(5'h1c, q);
		chk(q, 9'h000);
		chk({4'h0, oe, tx_irq, rx_irq, error_irq, pser}, 9'h000);
	endtask

	// Card clock period for each prescaler code, a gear step and a divisor
	task automatic t_clk();
		time t0;
		int p;
		wreg(`SCD_OFS_CARDMODE, 8'h01);
		wreg(`SCD_OFS_CTRL, 8'h01);
		@(posedge clk);
		chk({8'h0, cclk_oe}, 9'h001);
		for (int k = 0; k < 6; k++) begin
			wreg(`SCD_OFS_MODE, k < 4 ? 8'h28 + 8'(k) : 8'h28);
			wreg(`SCD_OFS_DIVISOR, k == 5 ? 8'h02 : 8'h00);
			gear <= k == 4 ? 2'h1 : 2'h0;
			p = 2 * (k == 5 ? 3 : 1) * (1 << (2 * (k < 4 ? k : 0) + (k == 4)));
			@(posedge cclk);
			@(posedge cclk);
			t0 = $time;
			@(posedge cclk);
			chk(9'(($time - t0) / 4), 9'(p));
		end
		wreg(`SCD_OFS_DIVISOR, 8'h00);
	endtask

	task automatic t_tx(input logic [7:0] d, input logic cv,
		input logic alt, input logic bad, output int dt);
		logic [7:0] n0;
		int n;
		time t0;
		wreg(`SCD_OFS_CTRL, 8'h01);
		wreg(`SCD_OFS_STATUS, 8'hc4);
		wreg(`SCD_OFS_MODE, {alt, 2'h1, cv, 4'h8});
		wreg(`SCD_OFS_CARDMODE, {4'h0, cv, cv, 2'h1});
		@(posedge clk);
		chk({7'h0, pser, oe}, 9'h002);
		repeat (744) @(posedge clk);
		wreg(`SCD_OFS_CTRL, 8'he1);
		rreg(`SCD_OFS_STATUS, q);
		chk(q & 9'h014, 9'h004);
		nack <= bad;
		n0 = got_n;
		wreg(`SCD_OFS_TXDATA, d);
		t0 = $time;
		rreg(`SCD_OFS_STATUS, q);
		chk(q & 9'h084, 9'h000);
		wait_card(n0);
		chk(got_raw, exp_line(d, cv, cv));
		if (bad) begin
			nack <= 1'b0;
			chk({7'h0, error_irq, tx_irq}, 9'h002);
			t0 = $time;
			wait_card(n0 + 8'h01);
			// Resend start at least 2 etu after the error signal ends
			chk({8'h0, ($time - t0) >= 64'd37200}, 9'h001);
			chk(got_raw, exp_line(d, cv, cv));
		end
		n = 0;
		while (tx_irq !== 1'b1 && n < 20000) begin
			@(posedge clk);
			n++;
		end
		dt = int'(($time - t0) / 4);
		chk({8'h0, tx_irq}, 9'h001);
		chk({8'h0, oe}, 9'h000);
	endtask

	task automatic t_rx(input logic [7:0] d, input logic bad);
		logic [7:0] n0;
		wreg(`SCD_OFS_CTRL, 8'h01);
		wreg(`SCD_OFS_STATUS, 8'h84);
		wreg(`SCD_OFS_MODE, 8'h28);
		wreg(`SCD_OFS_CARDMODE, 8'h01);
		repeat (744) @(posedge clk);
		wreg(`SCD_OFS_CTRL, 8'h51);
		n0 = got_n;
		craw <= exp_line(d, 1'b0, 1'b0) ^ {bad, 8'h00};
		send <= 1'b1;
		@(posedge clk);
		send <= 1'b0;
		wait_card(n0);
		chk({6'h0, err_seen, rx_irq, error_irq}, {6'h0, bad, !bad, bad});
		rreg(`SCD_OFS_STATUS, q);
		chk(q & 9'h068, bad ? 9'h008 : 9'h040);
		rreg(`SCD_OFS_RXDATA, q);
		chk(q, {1'b0, d});
		rreg(`SCD_OFS_STATUS, q);
		chk(q & 9'h040, 9'h000);
		chk({8'h0, oe}, 9'h000);
	endtask

	// Main sequence
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_clk();
		t_tx(8'h3b, 1'b0, 1'b0, 1'b0, d0);
		t_tx(8'h3f, 1'b1, 1'b1, 1'b0, d1);
		// Done point later by 557 base ticks without the alternate mode
		chk({8'h0, d0 - d1 > 1110 && d0 - d1 < 1118}, 9'h001);
		t_tx(8'h3b, 1'b0, 1'b0, 1'b1, dx);
		t_rx(8'h5a, 1'b0);
		t_rx(8'hc3, 1'b1);
		test_done();
	end
endmodule
